// *** iebank_top.sv ***
// two interrupt enable registers with wishbone access and request gating
`timescale 1ns/1ps
`include "iebank_map.svh"

// Function
// - register two holds enables at bits 13, 9, 7, 6, 5, 1.
// - register three holds enables at bits 14, 2, 1; others unimplemented.
// - enable one passes a request on; zero blocks it, flag unaffected.
// - register two bit 0 gates the serial-two fault request independently.
module iebank_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // raw requests from the peripherals, same clock
  input wire logic parallel_port_req,
  input wire logic compare_ch5_req,
  input wire logic capture_ch5_req,
  input wire logic capture_ch4_req,
  input wire logic capture_ch3_req,
  input wire logic serial_two_event_req,
  input wire logic serial_two_fault_req,
  input wire logic calendar_req,
  input wire logic twowire_two_master_req,
  input wire logic twowire_two_slave_req,
  // gated requests towards arbitration
  output logic [15:0] gated_req_two,
  output logic [15:0] gated_req_three
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    iebank_pkg::iebank_bus_t bus;
    logic [15:0] irq_enable_ctrl_two;
    logic [15:0] irq_enable_ctrl_three;
    logic [31:0] dat;
    logic ack;
    logic err;
  } iebank_state_t;

  iebank_state_t state_q;
  iebank_state_t state_d;
  logic [15:0] raw_two;
  logic [15:0] raw_three;
  // decoded view of the current bus request
  logic bus_take;
  logic hit_two;
  logic hit_three;
  logic hit_raw;

  // merge a bus write into a 16-bit register through the low two byte lanes
  function automatic logic [15:0] iebank_merge(
    input logic [15:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel,
    input logic [15:0] mask
  );
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wdat[15:8];
    end
    iebank_merge = v & mask; // unimplemented bits stay zero
  endfunction

  // ------------------------------------------------------------
  // register layout
  // ------------------------------------------------------------
  // enable two sits at offset 0x0 in data bits 15:0
  // - bit 13: parallel port request enable
  // - bit 9: compare channel 5 request enable
  // - bit 7: capture channel 5 request enable
  // - bit 6: capture channel 4 request enable
  // - bit 5: capture channel 3 request enable
  // - bit 1: serial two event request enable
  // - bit 0: serial two fault request enable, apart from the event enable
  // - all other bits: read zero, writes dropped
  // enable three sits at offset 0x4 in data bits 15:0
  // - bit 14: calendar request enable
  // - bit 2: two-wire two master request enable
  // - bit 1: two-wire two slave request enable
  // - all other bits: read zero, writes dropped
  // raw status sits at offset 0x8 and is read only
  // - bits 15:0: raw requests on the enable-two positions
  // - bits 31:16: raw requests on the enable-three positions
  // bits 31:16 of both enable registers always read zero
  // any other offset answers with err and changes nothing
  // limitation: only byte lanes 0 and 1 matter; sel bits 3:2 are ignored

  // ------------------------------------------------------------
  // raw request vectors laid out on the enable positions
  // ------------------------------------------------------------
  always_comb begin
    raw_two = 16'h0000;
    raw_three = 16'h0000;
    raw_two[`IEBANK_BIT_PARALLEL_PORT] = parallel_port_req;
    raw_two[`IEBANK_BIT_COMPARE_CH5] = compare_ch5_req;
    raw_two[`IEBANK_BIT_CAPTURE_CH5] = capture_ch5_req;
    raw_two[`IEBANK_BIT_CAPTURE_CH4] = capture_ch4_req;
    raw_two[`IEBANK_BIT_CAPTURE_CH3] = capture_ch3_req;
    raw_two[`IEBANK_BIT_SERIAL_TWO_EVENT] = serial_two_event_req;
    raw_two[`IEBANK_BIT_SERIAL_TWO_FAULT] = serial_two_fault_req; // own enable bit
    raw_three[`IEBANK_BIT_CALENDAR] = calendar_req;
    raw_three[`IEBANK_BIT_TWOWIRE_MASTER] = twowire_two_master_req;
    raw_three[`IEBANK_BIT_TWOWIRE_SLAVE] = twowire_two_slave_req;
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // only an idle slave takes a request, so a held strobe is never answered twice
  always_comb begin
    bus_take = wb_cyc_i && wb_stb_i && (state_q.bus == iebank_pkg::IEBANK_IDLE);
    hit_two = 1'b0;
    hit_three = 1'b0;
    hit_raw = 1'b0;
    if (wb_adr_i == `IEBANK_OFS_CTRL_TWO) begin
      hit_two = 1'b1;
    end else if (wb_adr_i == `IEBANK_OFS_CTRL_THREE) begin
      hit_three = 1'b1;
    end else if (wb_adr_i == `IEBANK_OFS_RAW_STATUS) begin
      hit_raw = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // bus slave: one wait-free ack, then one idle cycle
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.ack = 1'b0;
    state_d.err = 1'b0;
    case (state_q.bus)
      iebank_pkg::IEBANK_IDLE: begin
        if (bus_take) begin
          // ack and err both lead to the dead cycle
          state_d.bus = iebank_pkg::IEBANK_ACK;
          state_d.dat = 32'h0000_0000;
          if (hit_two) begin
            state_d.ack = 1'b1;
            state_d.dat = {16'h0000, state_q.irq_enable_ctrl_two};
            if (wb_we_i) begin
              state_d.irq_enable_ctrl_two = iebank_merge(state_q.irq_enable_ctrl_two, wb_dat_i,
                                                         wb_sel_i, `IEBANK_MASK_TWO);
            end
          end else if (hit_three) begin
            state_d.ack = 1'b1;
            state_d.dat = {16'h0000, state_q.irq_enable_ctrl_three};
            if (wb_we_i) begin
              state_d.irq_enable_ctrl_three = iebank_merge(state_q.irq_enable_ctrl_three, wb_dat_i,
                                                           wb_sel_i, `IEBANK_MASK_THREE);
            end
          end else if (hit_raw) begin
            // read-only view of raw requests, whatever the enables say
            state_d.ack = 1'b1;
            state_d.dat = {raw_three, raw_two};
          end else begin
            state_d.err = 1'b1; // unmapped offset
          end
        end
      end
      iebank_pkg::IEBANK_ACK: begin
        // one dead cycle keeps a held request from being answered twice
        state_d.bus = iebank_pkg::IEBANK_IDLE;
      end
      default: begin
        state_d.bus = iebank_pkg::IEBANK_IDLE;
      end
    endcase
  end

  // all state, enables included, clears on reset
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.irq_enable_ctrl_two <= `IEBANK_RST_TWO;
      state_q.irq_enable_ctrl_three <= `IEBANK_RST_THREE;
    end else begin
      state_q <= state_d;
    end
  end

  // bus outputs leave straight from the state flops
  // read data thus trails the take edge by one cycle, in step with ack
  assign wb_dat_o = state_q.dat;
  assign wb_ack_o = state_q.ack;
  assign wb_err_o = state_q.err;

  // ------------------------------------------------------------
  // request gating
  // ------------------------------------------------------------
  // enable two gates the first request vector
  iebank_gate #(.WIDTH(16)) u_gate_two (
    .clk(clk),
    .srst(srst),
    .req_raw(raw_two),
    .enable(state_q.irq_enable_ctrl_two),
    .req_gated(gated_req_two)
  );

  // enable three gates the second request vector
  iebank_gate #(.WIDTH(16)) u_gate_three (
    .clk(clk),
    .srst(srst),
    .req_raw(raw_three),
    .enable(state_q.irq_enable_ctrl_three),
    .req_gated(gated_req_three)
  );
endmodule

// *** iebank_map.svh ***
// register offsets, field positions, masks and reset values of the enable bank
`ifndef IEBANK_MAP_SVH
`define IEBANK_MAP_SVH
// ------------------------------------------------------------
// offsets (byte addresses on the register bus)
// ------------------------------------------------------------
`define IEBANK_OFS_CTRL_TWO 4'h0
`define IEBANK_OFS_CTRL_THREE 4'h4
`define IEBANK_OFS_RAW_STATUS 4'h8
// ------------------------------------------------------------
// field positions, enable register two
// ------------------------------------------------------------
`define IEBANK_BIT_PARALLEL_PORT 13
`define IEBANK_BIT_COMPARE_CH5 9
`define IEBANK_BIT_CAPTURE_CH5 7
`define IEBANK_BIT_CAPTURE_CH4 6
`define IEBANK_BIT_CAPTURE_CH3 5
`define IEBANK_BIT_SERIAL_TWO_EVENT 1
`define IEBANK_BIT_SERIAL_TWO_FAULT 0
// ------------------------------------------------------------
// field positions, enable register three
// ------------------------------------------------------------
`define IEBANK_BIT_CALENDAR 14
`define IEBANK_BIT_TWOWIRE_MASTER 2
`define IEBANK_BIT_TWOWIRE_SLAVE 1
// ------------------------------------------------------------
// implemented-bit masks and reset values
// ------------------------------------------------------------
`define IEBANK_MASK_TWO 16'h22E3
`define IEBANK_MASK_THREE 16'h4006
`define IEBANK_RST_TWO 16'h0000
`define IEBANK_RST_THREE 16'h0000
`endif

// *** iebank_pkg.sv ***
// types shared by the enable bank files
package iebank_pkg;
  typedef enum logic [0:0] {
    IEBANK_IDLE,
    IEBANK_ACK
  } iebank_bus_t;
endpackage

// *** iebank_gate.sv ***
// gates raw source requests with their enable bits, registered
`timescale 1ns/1ps
module iebank_gate #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // requests and enables
  input wire logic [WIDTH-1:0] req_raw,
  input wire logic [WIDTH-1:0] enable,
  // gated requests
  output logic [WIDTH-1:0] req_gated
);
  typedef struct packed {
    logic [WIDTH-1:0] gated;
  } iebank_gate_state_t;

  iebank_gate_state_t state_q;
  iebank_gate_state_t state_d;

  // a cleared enable only blocks the request; the source flag is never touched
  always_comb begin
    state_d = state_q;
    state_d.gated = req_raw & enable;
  end

  // registered so the controller sees a clean level
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign req_gated = state_q.gated;
endmodule

// *** iebank_chk_asserts.sv ***
// concurrent checks on the enable bank ports
`timescale 1ns/1ps
`include "iebank_map.svh"
module iebank_chk (
  // clock and reset
  input logic clk,
  input logic srst,
  // bus
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic wb_ack_o,
  input logic wb_err_o,
  input logic [3:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  // requests
  input logic parallel_port_req,
  input logic serial_two_fault_req,
  input logic [15:0] gated_req_two,
  input logic [15:0] gated_req_three
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // a taken request gets exactly one answer pulse
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o | wb_err_o);
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late or doubled");
  property p_two_unimpl;
    (gated_req_two & ~`IEBANK_MASK_TWO) == 16'h0;
  endproperty
  a_two_unimpl: assert property (p_two_unimpl) else $error("gated two outside mask");
  property p_three_unimpl;
    (gated_req_three & ~`IEBANK_MASK_THREE) == 16'h0;
  endproperty
  a_three_unimpl: assert property (p_three_unimpl) else $error("gated three outside mask");
  // a passed request needs its raw level one edge earlier
  property p_pass;
    gated_req_two[13] |-> $past(parallel_port_req);
  endproperty
  a_pass: assert property (p_pass) else $error("parallel port passed without request");
  property p_fault;
    gated_req_two[0] |-> $past(serial_two_fault_req);
  endproperty
  a_fault: assert property (p_fault) else $error("fault passed without request");
  property p_rd_zero;
    wb_ack_o && !wb_we_i && wb_adr_i == `IEBANK_OFS_CTRL_THREE |-> (wb_dat_o & ~32'h4006) == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unimplemented bit read high");
  property p_rst;
    $fell(srst) |-> gated_req_two == 16'h0 && gated_req_three == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("gated output high after reset");
endmodule
bind iebank_top iebank_chk u_chk (
  .clk(clk),
  .srst(srst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .parallel_port_req(parallel_port_req),
  .serial_two_fault_req(serial_two_fault_req),
  .gated_req_two(gated_req_two),
  .gated_req_three(gated_req_three)
);

// *** test_interrupt_enable_bank_two_three.sv ***
// self-checking bench for the enable bank
`timescale 1ns/1ps
`include "iebank_map.svh"
module test_interrupt_enable_bank_two_three;
  logic clk = 1'h0, srst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, wb_err_o, e;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, s;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, d;
  logic [15:0] gated_req_two, gated_req_three, r2 = 16'h0, r3 = 16'h0;
  int fails = 0, checks = 0, cycles = 0, m2 = 0, m3 = 0, i;
  // raw requests sit at their enable positions in the stimulus words
  wire parallel_port_req = r2[13], compare_ch5_req = r2[9], capture_ch5_req = r2[7];
  wire capture_ch4_req = r2[6], capture_ch3_req = r2[5], serial_two_event_req = r2[1];
  wire serial_two_fault_req = r2[0], calendar_req = r3[14];
  wire twowire_two_master_req = r3[2], twowire_two_slave_req = r3[1];
  iebank_top i_dut (
    .clk(clk),
    .srst(srst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .parallel_port_req(parallel_port_req),
    .compare_ch5_req(compare_ch5_req),
    .capture_ch5_req(capture_ch5_req),
    .capture_ch4_req(capture_ch4_req),
    .capture_ch3_req(capture_ch3_req),
    .serial_two_event_req(serial_two_event_req),
    .serial_two_fault_req(serial_two_fault_req),
    .calendar_req(calendar_req),
    .twowire_two_master_req(twowire_two_master_req),
    .twowire_two_slave_req(twowire_two_slave_req),
    .gated_req_two(gated_req_two),
    .gated_req_three(gated_req_three)
  );
  always #5 clk = ~clk;
  task automatic ck(string n, logic [31:0] x, logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // one classic cycle; waits for the answer, the timeout cuts a hang
  task automatic wb(logic w, logic [3:0] a, logic [3:0] sl, logic [31:0] dt);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= dt;
    do @(posedge clk); while (!(wb_ack_o | wb_err_o));
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // model: byte lanes merge, unimplemented bits never stick
  function automatic int lane(int o, int dt, logic [3:0] sl, int m);
    return (((sl[0] ? dt : o) & 32'hFF) | ((sl[1] ? dt : o) & 32'hFF00)) & m;
  endfunction
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'h5d1365a3));
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    for (i = 0; i < 40; i++) begin
      wb(1'h0, `IEBANK_OFS_CTRL_TWO, 4'h3, 32'h0);
      ck("enable two", m2, q);
      wb(1'h0, `IEBANK_OFS_CTRL_THREE, 4'h3, 32'h0);
      ck("enable three", m3, q);
      ck("gated two", m2 & r2, gated_req_two);
      ck("gated three", m3 & r3, gated_req_three);
      // the raw view shows every request whatever its enable says
      wb(1'h0, `IEBANK_OFS_RAW_STATUS, 4'h3, 32'h0);
      ck("raw status", {r3 & `IEBANK_MASK_THREE, r2 & `IEBANK_MASK_TWO}, q);
      r2 <= 16'($urandom);
      r3 <= 16'($urandom);
      d = $urandom;
      s = 4'($urandom);
      wb(1'h1, `IEBANK_OFS_CTRL_TWO, s, d);
      m2 = lane(m2, d, s, `IEBANK_MASK_TWO);
      d = $urandom;
      s = 4'($urandom);
      wb(1'h1, `IEBANK_OFS_CTRL_THREE, s, d);
      m3 = lane(m3, d, s, `IEBANK_MASK_THREE);
      // an unmapped write must be refused and leave both enables alone
      wb(1'h1, 4'hC, 4'hF, $urandom);
      ck("unmapped err", 32'h1, {31'h0, e});
    end
    // a reset in mid-run must clear both enables and the gated outputs
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    m2 = 0;
    m3 = 0;
    wb(1'h0, `IEBANK_OFS_CTRL_TWO, 4'h3, 32'h0);
    ck("reset two", m2, q);
    wb(1'h0, `IEBANK_OFS_CTRL_THREE, 4'h3, 32'h0);
    ck("reset three", m3, q);
    ck("reset gated two", 32'h0, gated_req_two);
    ck("reset gated three", 32'h0, gated_req_three);
    test_done;
  end
endmodule
